//--- design/cfa_core.sv
// Condition flags, interrupt masking and operand address forming
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module cfa_core
	import cfa_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire cfa_exe_req_t i_exe,
	output cfa_exe_rsp_t o_exe,
	input wire cfa_adr_req_t i_adr,
	output cfa_adr_rsp_t o_adr,
	input wire logic i_irq_req,
	input wire logic i_boundary,
	input wire logic i_stacked,
	output logic o_irq_take,
	output logic o_irq_mask,
	output logic [7:0] o_flags
);

	// ==========================================================
	// State
	logic [7:0] flags_reg;
	logic [7:0] flags_next;
	logic [7:0] res_next;
	logic [15:0] res16_next;
	cfa_exe_rsp_t exe_reg;
	cfa_adr_rsp_t adr_reg;
	cfa_adr_rsp_t adr_next;
	logic inhibit_reg;
	logic [7:0] int_cnt_reg;
	logic [31:0] prdata_reg;
	logic slverr_reg;

	// ==========================================================
	// Shared adder
	logic [7:0] add_b;
	logic add_cin;
	logic add_sub;
	logic [7:0] sum;
	logic sum_c;
	logic sum_h;
	logic sum_v;

	// Increment and decrement reuse the adder with a constant one
	always_comb begin
		add_b = i_exe.b;
		add_cin = 1'b0;
		add_sub = 1'b0;
		case (i_exe.op)
			OP_ADC: add_cin = flags_reg[FLAG_C];
			OP_SUB, OP_CMP: add_sub = 1'b1;
			OP_SBC: begin
				add_sub = 1'b1;
				add_cin = flags_reg[FLAG_C];
			end
			OP_INC: add_b = 8'h01;
			OP_DEC: begin
				add_b = 8'h01;
				add_sub = 1'b1;
			end
			default: add_b = i_exe.b;
		endcase
	end

	cfa_adder u_adder (
		.i_a(i_exe.a),
		.i_b(add_b),
		.i_cin(add_cin),
		.i_sub(add_sub),
		.o_sum(sum),
		.o_carry(sum_c),
		.o_half(sum_h),
		.o_ovf(sum_v)
	);

	// ==========================================================
	// Decimal adjust correction
	logic fix_lo;
	logic fix_hi;
	logic [7:0] daa_sum;

	assign fix_lo = flags_reg[FLAG_H] || (i_exe.a[3:0] > BCD_DIGIT_MAX);
	assign fix_hi = flags_reg[FLAG_C] || (i_exe.a > BCD_BYTE_MAX);
	assign daa_sum = i_exe.a + {(fix_hi ? BCD_FIX : 4'h0), (fix_lo ? BCD_FIX : 4'h0)};

	// ==========================================================
	// Result and flag update
	// Start from the old flags so untouched bits hold
	always_comb begin
		flags_next = flags_reg;
		res_next = 8'h00;
		res16_next = 16'h0000;
		case (i_exe.op)
			OP_ADD, OP_ADC: begin
				res_next = sum;
				flags_next[FLAG_H] = sum_h;
				flags_next[FLAG_V] = sum_v;
				flags_next[FLAG_C] = sum_c;
			end
			OP_SUB, OP_SBC, OP_CMP: begin
				res_next = sum;
				flags_next[FLAG_V] = sum_v;
				flags_next[FLAG_C] = sum_c;
			end
			OP_INC, OP_DEC: begin
				res_next = sum;
				flags_next[FLAG_V] = sum_v;
			end
			OP_AND: begin
				res_next = i_exe.a & i_exe.b;
				flags_next[FLAG_V] = 1'b0;
			end
			OP_OR: begin
				res_next = i_exe.a | i_exe.b;
				flags_next[FLAG_V] = 1'b0;
			end
			OP_XOR: begin
				res_next = i_exe.a ^ i_exe.b;
				flags_next[FLAG_V] = 1'b0;
			end
			OP_LD8: begin
				res_next = i_exe.a;
				flags_next[FLAG_V] = 1'b0;
			end
			OP_LD16: begin
				res16_next = i_exe.w;
				flags_next[FLAG_V] = 1'b0;
			end
			OP_ASL: begin
				res_next = {i_exe.a[6:0], 1'b0};
				flags_next[FLAG_C] = i_exe.a[7];
				flags_next[FLAG_V] = i_exe.a[7] ^ i_exe.a[6];
			end
			OP_LSR: begin
				res_next = {1'b0, i_exe.a[7:1]};
				flags_next[FLAG_C] = i_exe.a[0];
				flags_next[FLAG_V] = i_exe.a[0];
			end
			OP_ROL: begin
				res_next = {i_exe.a[6:0], flags_reg[FLAG_C]};
				flags_next[FLAG_C] = i_exe.a[7];
				flags_next[FLAG_V] = i_exe.a[7] ^ i_exe.a[6];
			end
			OP_ROR: begin
				res_next = {flags_reg[FLAG_C], i_exe.a[7:1]};
				flags_next[FLAG_C] = i_exe.a[0];
				flags_next[FLAG_V] = i_exe.a[0] ^ flags_reg[FLAG_C];
			end
			OP_BTST: begin
				res_next = i_exe.a;
				flags_next[FLAG_C] = i_exe.a[i_exe.bit_sel];
			end
			OP_DAA: begin
				res_next = daa_sum;
				flags_next[FLAG_C] = fix_hi;
			end
			OP_CLI: flags_next[FLAG_I] = 1'b0;
			OP_SEI: flags_next[FLAG_I] = 1'b1;
			OP_TAP: flags_next = i_exe.a;
			OP_TPA: res_next = flags_reg;
			OP_SEC: flags_next[FLAG_C] = 1'b1;
			OP_CLC: flags_next[FLAG_C] = 1'b0;
			default: res_next = 8'h00;
		endcase
		// Sign and zero follow the 8- or 16-bit result, except NONE, BTST, TPA, CLI, SEI, TAP, SEC and CLC, which keep them as set above
		case (i_exe.op)
			OP_LD16: begin
				flags_next[FLAG_N] = res16_next[15];
				flags_next[FLAG_Z] = (res16_next == 16'h0000);
			end
			OP_NONE, OP_BTST, OP_CLI, OP_SEI, OP_TAP, OP_TPA, OP_SEC, OP_CLC: begin
				flags_next[FLAG_N] = flags_next[FLAG_N];
			end
			default: begin
				flags_next[FLAG_N] = res_next[7];
				flags_next[FLAG_Z] = (res_next == 8'h00);
			end
		endcase
		flags_next = flags_next | FLAGS_FIXED;
	end

	// ==========================================================
	// Flag register
	// Stacking wins over an instruction, which wins over software
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			flags_reg <= FLAGS_RST;
		end else if (i_stacked) begin
			flags_reg[FLAG_I] <= 1'b1;
		end else if (i_exe.valid) begin
			flags_reg <= flags_next;
		end else if (i_psel && i_penable && i_pwrite && i_paddr == REG_FLAGS) begin
			flags_reg <= i_pwdata[7:0] | FLAGS_FIXED;
		end
	end

	// ==========================================================
	// Interrupt gating
	// Inhibit is set only when the mask really drops from one
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			inhibit_reg <= 1'b0;
		end else if (i_exe.valid && !i_stacked && flags_reg[FLAG_I] && !flags_next[FLAG_I]) begin
			inhibit_reg <= 1'b1;
		end else if (i_boundary) begin
			inhibit_reg <= 1'b0;
		end
	end

	assign o_irq_take = i_boundary && i_irq_req && !flags_reg[FLAG_I] && !inhibit_reg;
	assign o_irq_mask = flags_reg[FLAG_I];
	assign o_flags = flags_reg;

	// Count of interrupts taken, wraps
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			int_cnt_reg <= 8'h00;
		end else if (o_irq_take) begin
			int_cnt_reg <= int_cnt_reg + 8'h01;
		end
	end

	// ==========================================================
	// Execution result
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			exe_reg <= '0;
		end else begin
			exe_reg.valid <= i_exe.valid;
			if (i_exe.valid) begin
				exe_reg.data <= res_next;
				exe_reg.data16 <= res16_next;
			end
		end
	end

	assign o_exe = exe_reg;

	// ==========================================================
	// Operand addressing
	logic [15:0] src_end;
	logic [15:0] src_ea;
	logic src_mem;
	logic [15:0] dst_end;
	logic [15:0] dst_ea;
	logic dst_mem;
	logic [1:0] src_len;
	logic [7:0] dst_b0;
	logic [7:0] dst_b1;
	logic nv;
	logic taken;

	// Source field sits right after the opcode
	cfa_adrgen u_src (
		.i_mode(i_adr.src_mode),
		.i_wide(i_adr.src_wide),
		.i_base(i_adr.pc + 16'h0001),
		.i_byte0(i_adr.bytes[0]),
		.i_byte1(i_adr.bytes[1]),
		.o_ea(src_ea),
		.o_end(src_end),
		.o_mem(src_mem)
	);

	// Destination or branch field follows the source bytes
	assign src_len = 2'(src_end - i_adr.pc - 16'h0001);
	assign dst_b0 = i_adr.bytes[src_len];
	assign dst_b1 = (src_len == 2'd3) ? 8'h00 : i_adr.bytes[2'(src_len + 2'd1)];

	cfa_adrgen u_dst (
		.i_mode(i_adr.dst_mode),
		.i_wide(1'b0),
		.i_base(src_end),
		.i_byte0(dst_b0),
		.i_byte1(dst_b1),
		.o_ea(dst_ea),
		.o_end(dst_end),
		.o_mem(dst_mem)
	);

	// Branch condition on the flags left by the previous operation
	assign nv = flags_reg[FLAG_N] ^ flags_reg[FLAG_V];
	always_comb begin
		case (i_adr.cond)
			CC_ALWAYS: taken = 1'b1;
			CC_GT: taken = !(flags_reg[FLAG_Z] || nv);
			CC_GE: taken = !nv;
			CC_LE: taken = flags_reg[FLAG_Z] || nv;
			CC_LT: taken = nv;
			CC_EQ: taken = flags_reg[FLAG_Z];
			CC_NE: taken = !flags_reg[FLAG_Z];
			CC_CS: taken = flags_reg[FLAG_C];
			CC_CC: taken = !flags_reg[FLAG_C];
			default: taken = 1'b0;
		endcase
	end

	// Relative target only when a relative field exists and holds
	always_comb begin
		adr_next = '0;
		adr_next.valid = i_adr.valid;
		adr_next.src_ea = src_ea;
		adr_next.dst_ea = dst_ea;
		adr_next.src_mem = src_mem;
		adr_next.dst_mem = dst_mem;
		adr_next.next_pc = dst_end;
		if (taken && i_adr.src_mode == AM_REL) begin
			adr_next.taken = 1'b1;
			adr_next.next_pc = src_ea;
		end else if (taken && i_adr.dst_mode == AM_REL) begin
			adr_next.taken = 1'b1;
			adr_next.next_pc = dst_ea;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			adr_reg <= '0;
		end else begin
			adr_reg <= adr_next;
		end
	end

	assign o_adr = adr_reg;

	// ==========================================================
	// APB slave
	// Read data captured in the setup cycle, so no wait states
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			prdata_reg <= 32'h0000_0000;
			slverr_reg <= 1'b0;
		end else if (i_psel && !i_penable) begin
			slverr_reg <= 1'b0;
			case (i_paddr)
				REG_FLAGS: prdata_reg <= {24'h00_0000, flags_reg};
				REG_RESULT: prdata_reg <= {exe_reg.data16, 8'h00, exe_reg.data};
				REG_STATUS: begin
					prdata_reg <= 32'h0000_0000;
					prdata_reg[ST_INHIBIT] <= inhibit_reg;
					prdata_reg[ST_MASK] <= flags_reg[FLAG_I];
					prdata_reg[ST_REQ] <= i_irq_req;
					prdata_reg[ST_CNT_LO +: 8] <= int_cnt_reg;
				end
				default: begin
					prdata_reg <= 32'h0000_0000;
					slverr_reg <= 1'b1;
				end
			endcase
		end
	end

	assign o_pready = 1'b1;
	assign o_prdata = prdata_reg;
	assign o_pslverr = slverr_reg && i_psel && i_penable;

endmodule : cfa_core

//--- design/cfa_pkg.sv
// Package: constants and carrier types for the flag and addressing block
package cfa_pkg;

	// ==========================================================
	// Flag register layout
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_I = 3;
	localparam int FLAG_H = 4;
	localparam int FLAG_V = 7;
	localparam logic [7:0] FLAGS_FIXED = 8'h60;
	localparam logic [7:0] FLAGS_RST = 8'h68;

	// ==========================================================
	// Arithmetic constants
	localparam logic [7:0] ZERO_PAGE = 8'h00;
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
	localparam logic [3:0] BCD_FIX = 4'h6;

	// ==========================================================
	// Register offsets (APB byte addresses)
	localparam int ADDR_W = 12;
	localparam logic [11:0] REG_FLAGS = 12'h000;
	localparam logic [11:0] REG_RESULT = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam int ST_INHIBIT = 0;
	localparam int ST_MASK = 1;
	localparam int ST_REQ = 2;
	localparam int ST_CNT_LO = 8;

	// ==========================================================
	// Enumerations
	typedef enum logic [4:0] {
		OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CMP, OP_AND, OP_OR,
		OP_XOR, OP_LD8, OP_LD16, OP_ASL, OP_LSR, OP_ROL, OP_ROR, OP_BTST,
		OP_INC, OP_DEC, OP_DAA, OP_CLI, OP_SEI, OP_TAP, OP_TPA, OP_SEC, OP_CLC
	} cfa_op_t;
	typedef enum logic [2:0] {AM_INH, AM_REL, AM_IMM, AM_DIR, AM_EXT} cfa_mode_t;
	typedef enum logic [3:0] {
		CC_ALWAYS, CC_NEVER, CC_GT, CC_GE, CC_LE, CC_LT, CC_EQ, CC_NE, CC_CS, CC_CC
	} cfa_cond_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic valid;
		cfa_op_t op;
		logic [7:0] a;
		logic [7:0] b;
		logic [2:0] bit_sel;
		logic [15:0] w;
	} cfa_exe_req_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic [15:0] data16;
	} cfa_exe_rsp_t;
	typedef struct packed {
		logic valid;
		cfa_mode_t src_mode;
		cfa_mode_t dst_mode;
		logic src_wide;
		cfa_cond_t cond;
		logic [15:0] pc;
		logic [3:0][7:0] bytes;
	} cfa_adr_req_t;
	typedef struct packed {
		logic valid;
		logic [15:0] src_ea;
		logic [15:0] dst_ea;
		logic src_mem;
		logic dst_mem;
		logic taken;
		logic [15:0] next_pc;
	} cfa_adr_rsp_t;

endpackage : cfa_pkg

//--- design/cfa_adder.sv
// Eight-bit adder/subtractor with carry, half-carry and overflow outputs
`timescale 1ns/1ps
module cfa_adder
	import cfa_pkg::*;
(
	input wire logic [7:0] i_a,
	input wire logic [7:0] i_b,
	input wire logic i_cin,
	input wire logic i_sub,
	output logic [7:0] o_sum,
	output logic o_carry,
	output logic o_half,
	output logic o_ovf
);

	// ==========================================================
	// Datapath
	logic [7:0] bx;
	logic cx;
	logic [8:0] full;
	logic [4:0] low;

	// Subtract as a + ~b + ~borrow, so one adder serves both
	assign bx = i_sub ? ~i_b : i_b;
	assign cx = i_sub ? ~i_cin : i_cin;
	assign full = {1'b0, i_a} + {1'b0, bx} + {8'h00, cx};
	assign low = {1'b0, i_a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};
	assign o_sum = full[7:0];
	assign o_carry = i_sub ? ~full[8] : full[8];
	assign o_half = low[4];
	assign o_ovf = (i_a[7] == bx[7]) && (full[7] != i_a[7]);

endmodule : cfa_adder

//--- design/cfa_adrgen.sv
// Effective address former for one operand field of an instruction
`timescale 1ns/1ps
module cfa_adrgen
	import cfa_pkg::*;
(
	input wire cfa_mode_t i_mode,
	input wire logic i_wide,
	input wire logic [15:0] i_base,
	input wire logic [7:0] i_byte0,
	input wire logic [7:0] i_byte1,
	output logic [15:0] o_ea,
	output logic [15:0] o_end,
	output logic o_mem
);

	// ==========================================================
	// Mode decode
	always_comb begin
		o_ea = 16'h0000;
		o_end = i_base;
		o_mem = 1'b0;
		case (i_mode)
			AM_INH: begin
				o_end = i_base;
			end
			AM_REL: begin
				o_end = i_base + 16'h0001;
				o_ea = o_end + {{8{i_byte0[7]}}, i_byte0};
			end
			AM_IMM: begin
				o_ea = i_base;
				o_end = i_base + (i_wide ? 16'h0002 : 16'h0001);
			end
			AM_DIR: begin
				o_ea = {ZERO_PAGE, i_byte0};
				o_end = i_base + 16'h0001;
				o_mem = 1'b1;
			end
			AM_EXT: begin
				o_ea = {i_byte0, i_byte1};
				o_end = i_base + 16'h0002;
				o_mem = 1'b1;
			end
			default: begin
				o_end = i_base;
			end
		endcase
	end

endmodule : cfa_adrgen

//--- sim/cfa_core_sva.sv
// Assertion checker for the flag and addressing core
`timescale 1ns/1ps
module cfa_core_sva
	import cfa_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire cfa_exe_req_t i_exe,
	input wire cfa_exe_rsp_t o_exe,
	input wire cfa_adr_req_t i_adr,
	input wire cfa_adr_rsp_t o_adr,
	input wire logic i_irq_req,
	input wire logic i_boundary,
	input wire logic i_stacked,
	input wire logic o_irq_take,
	input wire logic o_irq_mask,
	input wire logic [7:0] o_flags
);
	// ==========================================================
	// Reference arithmetic for sums taken by the core
	logic [8:0] sum9;
	logic [4:0] nib;
	logic add_ovf;
	logic add_go;
	logic ld_go;
	assign sum9 = {1'b0, i_exe.a} + {1'b0, i_exe.b};
	assign nib = {1'b0, i_exe.a[3:0]} + {1'b0, i_exe.b[3:0]};
	assign add_ovf = (i_exe.a[7] == i_exe.b[7]) && (sum9[7] != i_exe.a[7]);
	// Stacking wins over an op, so those cycles are left out
	assign add_go = i_exe.valid && (i_exe.op == OP_ADD) && !i_stacked;
	assign ld_go = i_exe.valid && (i_exe.op == OP_LD16) && !i_stacked;
	// Own record of a mask drop by an op, held until the next boundary
	logic clr_pend_reg;
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			clr_pend_reg <= 1'b0;
		end else if (i_exe.valid && !i_stacked && o_irq_mask && (i_exe.op == OP_CLI
			|| (i_exe.op == OP_TAP && !i_exe.a[FLAG_I]))) begin
			clr_pend_reg <= 1'b1;
		end else if (i_boundary) begin
			clr_pend_reg <= 1'b0;
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	// ==========================================================
	// Properties
	chk_fixed_ones: assert property (o_flags[6:5] == 2'b11)
		else $error("fixed flag bits not one");
	chk_add_ovf: assert property (add_go |=> o_flags[FLAG_V] == $past(add_ovf))
		else $error("overflow flag wrong after sum");
	chk_half_carry: assert property (add_go |=> o_flags[FLAG_H] == $past(nib[4]))
		else $error("half carry wrong after sum");
	chk_carry_out: assert property (add_go |=> o_flags[FLAG_C] == $past(sum9[8]))
		else $error("carry wrong after sum");
	chk_irq_gate: assert property (o_irq_take |-> !o_irq_mask && i_boundary && i_irq_req)
		else $error("interrupt taken while masked or idle");
	chk_stack_mask: assert property (i_stacked |=> o_irq_mask)
		else $error("mask not set after stacking");
	chk_cli_hold: assert property (clr_pend_reg && i_boundary |-> !o_irq_take)
		else $error("interrupt taken right after mask clear");
	chk_load_flags: assert property (ld_go |=> o_flags[2:1] == {$past(i_exe.w[15]),
		$past(i_exe.w) == 16'h0000} && $stable(o_flags[FLAG_C]))
		else $error("load flags wrong");
	chk_zero_page: assert property (i_adr.valid && i_adr.src_mode == AM_DIR
		|=> o_adr.src_ea == {ZERO_PAGE, $past(i_adr.bytes[0])})
		else $error("zero page address wrong");
	chk_full_addr: assert property (i_adr.valid && i_adr.src_mode == AM_EXT
		|=> o_adr.src_ea == {$past(i_adr.bytes[0]), $past(i_adr.bytes[1])})
		else $error("full address wrong");
	chk_reg_only: assert property (i_adr.valid && i_adr.src_mode == AM_INH |=> !o_adr.src_mem)
		else $error("memory access in register mode");
endmodule : cfa_core_sva

bind cfa_core cfa_core_sva u_sva (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_exe(i_exe),
	.o_exe(o_exe), .i_adr(i_adr), .o_adr(o_adr), .i_irq_req(i_irq_req),
	.i_boundary(i_boundary), .i_stacked(i_stacked), .o_irq_take(o_irq_take),
	.o_irq_mask(o_irq_mask), .o_flags(o_flags));

//--- sim/cfa_mem_model.sv
// Behavioural model of the shared program and data memory
`timescale 1ns/1ps
module cfa_mem_model
	import cfa_pkg::*;
(
	input wire logic [15:0] i_pc,
	output logic [3:0][7:0] o_bytes
);
	// ==========================================================
	// Storage, one linear 64K byte space
	logic [7:0] store [0:65535];
	// Unwritten bytes give an address pattern, never a stale value
	initial begin
		for (int k = 0; k < 65536; k++) begin
			store[k] = ~k[7:0];
		end
	end
	// Byte after the opcode first; the 16-bit address wraps
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			o_bytes[k] = store[i_pc + 16'(k + 1)];
		end
	end
endmodule : cfa_mem_model

//--- sim/tb_cpu_flags_and_operand_addressing.sv
// Self-checking bench for the flag and addressing core
`timescale 1ns/1ps
module tb_cpu_flags_and_operand_addressing;
	import cfa_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	cfa_exe_req_t exe = '0;
	cfa_exe_rsp_t ersp;
	cfa_adr_req_t areq = '0;
	cfa_adr_req_t ain;
	cfa_adr_rsp_t arsp;
	logic irq = 1'b0;
	logic bnd = 1'b0;
	logic stk = 1'b0;
	logic take, imask, tk, err;
	logic [7:0] flags;
	logic [3:0][7:0] mbytes;
	logic [31:0] rd;
	int error_cnt = 0;
	int comparisons = 0;
	logic [7:0] va [4] = '{8'h09, 8'h7f, 8'hff, 8'h80};
	logic [7:0] vb [4] = '{8'h01, 8'h01, 8'h01, 8'h80};
	logic [7:0] da [3] = '{8'h09, 8'h90, 8'h99};
	logic [7:0] db [3] = '{8'h09, 8'h90, 8'h01};
	logic [7:0] dx [3] = '{8'h18, 8'h80, 8'h00};

	// ==========================================================
	// Clock, design and memory
	always #2.5 clk = ~clk;
	cfa_core dut (.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_exe(exe), .o_exe(ersp), .i_adr(ain),
		.o_adr(arsp), .i_irq_req(irq), .i_boundary(bnd), .i_stacked(stk),
		.o_irq_take(take), .o_irq_mask(imask), .o_flags(flags));
	cfa_mem_model mem (.i_pc(areq.pc), .o_bytes(mbytes));
	// Operand bytes always come from memory at the request pc
	always_comb begin
		ain = areq;
		ain.bytes = mbytes;
	end

	// ==========================================================
	// Checking and closing
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tally_and_finish;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// Expected flags of a sum, mask assumed set
	function automatic logic [7:0] addf(input logic [7:0] a, input logic [7:0] b, input logic ci);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		return {(a[7] == b[7]) && (s[7] != a[7]), 2'b11, h[4], 1'b1, s[7], s[7:0] == 8'h00, s[8]};
	endfunction : addf

	// ==========================================================
	// Access tasks
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Never assume the wait count; pready ends it, the bound of 16 stops a hang
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			error_cnt++;
			$display("[ERR] %0t bus hang", $time);
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic op(input cfa_op_t o, input logic [7:0] a, input logic [7:0] b,
		input logic [15:0] w);
		@(posedge clk);
		exe <= '{1'b1, o, a, b, 3'd0, w};
		@(posedge clk);
		exe.valid <= 1'b0;
		#1;
	endtask : op
	task automatic adr(input cfa_mode_t s, input cfa_mode_t d, input cfa_cond_t c,
		input logic [15:0] pc);
		@(posedge clk);
		areq <= '{1'b1, s, d, 1'b1, c, pc, 32'h0};
		@(posedge clk);
		areq.valid <= 1'b0;
		#1;
	endtask : adr
	// Boundary pulse; take is combinational, so sample while high
	task automatic pulse;
		@(posedge clk);
		bnd <= 1'b1;
		#1;
		tk = take;
		@(posedge clk);
		bnd <= 1'b0;
	endtask : pulse

	// ==========================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		mem.store[16'h1001] = 8'h40;
		mem.store[16'h1002] = 8'hfe;
		mem.store[16'h2001] = 8'h12;
		mem.store[16'h2002] = 8'h34;
		mem.store[16'h4001] = 8'h80;
		mem.store[16'h5001] = 8'h11;
		mem.store[16'h5002] = 8'h22;
		#1;
		chk(flags, 8'h68);
		apb(1'b1, REG_FLAGS, 32'h0);
		apb(1'b0, REG_FLAGS, 32'h0);
		chk(rd[7:0], 8'h60);
		apb(1'b0, 12'h00c, 32'h0);
		chk(err, 1'b1);
		apb(1'b1, REG_FLAGS, 32'hff);
		for (int i = 0; i < 4; i++) begin
			op(OP_ADD, va[i], vb[i], 16'h0);
			chk(ersp.data, 8'(va[i] + vb[i]));
			chk(ersp.valid, 1'b1);
			chk(flags, addf(va[i], vb[i], 1'b0));
		end
		op(OP_ADC, 8'h10, 8'h20, 16'h0);
		chk(flags, addf(8'h10, 8'h20, 1'b1));
		op(OP_ADD, 8'hff, 8'h01, 16'h0);
		op(OP_LD16, 8'h0, 8'h0, 16'h8000);
		chk(flags, 8'h7d);
		apb(1'b0, REG_RESULT, 32'h0);
		chk(rd, 32'h8000_0000);
		op(OP_LD16, 8'h0, 8'h0, 16'h0000);
		chk(flags, 8'h7b);
		op(OP_SUB, 8'h00, 8'h01, 16'h0);
		chk({ersp.data, flags[7], flags[2:0]}, 12'hff5);
		op(OP_ASL, 8'h81, 8'h00, 16'h0);
		chk({ersp.data, flags[0]}, 9'h005);
		for (int i = 0; i < 3; i++) begin
			op(OP_ADD, da[i], db[i], 16'h0);
			op(OP_DAA, 8'(da[i] + db[i]), 8'h00, 16'h0);
			chk(ersp.data, dx[i]);
		end
		op(OP_ADD, 8'h7f, 8'h01, 16'h0);
		// Overflow set and negative set: greater and greater-equal hold
		for (int i = 2; i < 6; i++) begin
			adr(AM_REL, AM_INH, cfa_cond_t'(i), 16'h4000);
			chk({arsp.taken, arsp.next_pc}, {i < 4, (i < 4) ? 16'h3f82 : 16'h4002});
		end
		op(OP_SEC, 8'h00, 8'h00, 16'h0);
		adr(AM_DIR, AM_REL, CC_CS, 16'h1000);
		chk({arsp.src_ea, arsp.src_mem}, 17'h00081);
		chk({arsp.taken, arsp.next_pc}, 17'h11001);
		adr(AM_EXT, AM_INH, CC_NEVER, 16'h2000);
		chk(arsp.src_ea, 16'h1234);
		adr(AM_IMM, AM_INH, CC_NEVER, 16'h3000);
		chk(arsp.src_ea, 16'h3001);
		adr(AM_INH, AM_INH, CC_NEVER, 16'h3000);
		chk(arsp.src_mem, 1'b0);
		adr(AM_DIR, AM_DIR, CC_NEVER, 16'h5000);
		chk({arsp.src_ea, arsp.dst_ea}, 32'h0011_0022);
		chk({arsp.valid, arsp.dst_mem}, 2'b11);
		@(posedge clk);
		irq <= 1'b1;
		pulse();
		chk(tk, 1'b0);
		op(OP_CLI, 8'h00, 8'h00, 16'h0);
		chk(imask, 1'b0);
		pulse();
		chk(tk, 1'b0);
		pulse();
		chk(tk, 1'b1);
		@(posedge clk);
		stk <= 1'b1;
		@(posedge clk);
		stk <= 1'b0;
		#1;
		chk(imask, 1'b1);
		op(OP_TAP, 8'h00, 8'h00, 16'h0);
		pulse();
		chk(tk, 1'b0);
		pulse();
		chk(tk, 1'b1);
		// Status: inhibit clear, mask clear, request high, two taken
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd, 32'h0000_0204);
		tally_and_finish();
	end
endmodule : tb_cpu_flags_and_operand_addressing
